// ---- rtl/hcp_hiccup.sv ----
// Purpose: Overcurrent hiccup sequencer and compensation latch
// Assumes: nrst is driven by bias_undervoltage_lockout release
// Notes: All pin inputs are synchronised before use
`timescale 1ns/1ps
module hcp_hiccup
  import hcp_pkg::*;
#(
  parameter int unsigned OVL_N = OVL_CYCLES,
  parameter int unsigned PAUSE_N = PAUSE_CYCLES,
  parameter int unsigned SS_N = SS_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Analog and oscillator inputs
  input wire hcp_cmp_t cmp_in,
  input wire logic cycle_start,
  input wire logic compensation_select_pin,
  input wire logic pwm_on,
  // Outputs
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic soft_start_run,
  output logic soft_start_done,
  output logic ss_clamp_en,
  output logic comp_internal,
  output logic hiccup_active
);
  ////////////////////////////////////////////////////////////////
  hcp_cmp_t cmp;
  logic cyc_raw, cyc_d, cyc_stb, comp_s, pwm_s;
  logic [$clog2(OVL_N+1)-1:0] ovl_cnt;
  logic [2:0] clean_cnt;
  logic [$clog2(PAUSE_N+1)-1:0] pause_cnt;
  logic [$clog2(SS_N+1)-1:0] ss_cnt;
  logic [4:0] evt_cnt;
  logic oc_seen, oc_flag, trip, comp_taken, prot_en;
  logic [1:0] settle;
  hcp_state_t state;

  // Synchronise all pin inputs
  hcp_sync #(.W(6)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din({cmp_in, cycle_start, compensation_select_pin, pwm_on}),
    .dout({cmp, cyc_raw, comp_s, pwm_s})
  );

  // Cycle boundary edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) cyc_d <= 1'b0;
    else cyc_d <= cyc_raw;
  end
  assign cyc_stb = cyc_raw & ~cyc_d;

  ////////////////////////////////////////////////////////////////
  // Hold off the latch until the synchroniser carries real pin data
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) settle <= '0;
    else settle <= {settle[0], 1'b1};
  end

  // Compensation latched once, after the synchroniser has filled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      comp_taken <= 1'b0;
      comp_internal <= 1'b0;
    end else if (!comp_taken && settle[1]) begin
      comp_taken <= 1'b1;
      comp_internal <= comp_s;
    end
  end

  // Overcurrent seen within current cycle, flag per cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oc_seen <= 1'b0;
      oc_flag <= 1'b0;
    end else if (cyc_stb) begin
      oc_flag <= oc_seen | cmp.curr_limit;
      oc_seen <= 1'b0;
    end else if (cmp.curr_limit) begin
      oc_seen <= 1'b1;
    end
  end
  assign trip = oc_seen | cmp.curr_limit;

  // Protection armed in run, and in soft start once feedback is above its level
  assign prot_en = (state == HCP_RUN) | (state == HCP_SOFT && cmp.fb_above_hiccup);

  ////////////////////////////////////////////////////////////////
  // Overload and clean-cycle counters
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovl_cnt <= '0;
      clean_cnt <= '0;
    end else if (state == HCP_PAUSE || !prot_en) begin
      ovl_cnt <= '0;
      clean_cnt <= '0;
    end else if (cyc_stb && oc_flag) begin
      clean_cnt <= '0;
      ovl_cnt <= ovl_cnt + 1'b1;
    end else if (cyc_stb && ovl_cnt != '0) begin
      if (clean_cnt == 3'(CLEAN_CYCLES - 1)) begin
        ovl_cnt <= '0;
        clean_cnt <= '0;
      end else begin
        clean_cnt <= clean_cnt + 1'b1;
        ovl_cnt <= ovl_cnt + 1'b1;
      end
    end
  end

  // Overcurrent event counter for clamp enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      evt_cnt <= '0;
      ss_clamp_en <= 1'b0;
    end else if (state == HCP_PAUSE) begin
      evt_cnt <= '0;
      ss_clamp_en <= 1'b0;
    end else begin
      if (cyc_stb && oc_flag && evt_cnt != 5'(CLAMP_EVENTS))
        evt_cnt <= evt_cnt + 1'b1;
      ss_clamp_en <= (evt_cnt == 5'(CLAMP_EVENTS)) & oc_flag;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode sequencer, pause and soft-start timers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= HCP_SOFT;
      pause_cnt <= '0;
      ss_cnt <= '0;
    end else begin
      unique case (state)
        HCP_SOFT: begin
          if (ss_cnt == ($bits(ss_cnt))'(SS_N - 1)) state <= HCP_RUN;
          else ss_cnt <= ss_cnt + 1'b1;
          if (ovl_cnt == ($bits(ovl_cnt))'(OVL_N)) begin
            state <= HCP_PAUSE;
            ss_cnt <= '0;
          end
        end
        HCP_RUN: begin
          if (ovl_cnt == ($bits(ovl_cnt))'(OVL_N)) begin
            state <= HCP_PAUSE;
            pause_cnt <= '0;
          end
        end
        HCP_PAUSE: begin
          if (pause_cnt == ($bits(pause_cnt))'(PAUSE_N)) begin
            state <= HCP_SOFT;
            ss_cnt <= '0;
            pause_cnt <= '0;
          end else if (cyc_stb) begin
            pause_cnt <= pause_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      soft_start_run <= 1'b0;
      soft_start_done <= 1'b0;
      hiccup_active <= 1'b0;
    end else begin
      high_side_gate_drive <= pwm_s & ~trip & (state != HCP_PAUSE);
      low_side_gate_drive <= ~pwm_s & (state != HCP_PAUSE);
      soft_start_run <= (state != HCP_PAUSE);
      soft_start_done <= (state == HCP_RUN);
      hiccup_active <= (state == HCP_PAUSE);
    end
  end

  ////////////////////////////////////////////////////////////////
  chk_hs_trip_off: assert property (@(posedge core_clk) disable iff (!nrst)
    trip |=> !high_side_gate_drive) else $error("high side on during trip");
  chk_pause_drv_off: assert property (@(posedge core_clk) disable iff (!nrst)
    state == HCP_PAUSE |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("drive on in pause");
  chk_ovl_expire: assert property (@(posedge core_clk) disable iff (!nrst)
    state == HCP_RUN && ovl_cnt == ($bits(ovl_cnt))'(OVL_N) |=> state == HCP_PAUSE)
    else $error("no pause at overload expiry");
  chk_pause_end: assert property (@(posedge core_clk) disable iff (!nrst)
    state == HCP_PAUSE && pause_cnt == ($bits(pause_cnt))'(PAUSE_N) |=> state == HCP_SOFT)
    else $error("no restart after pause");
  chk_clamp_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    ss_clamp_en |-> $past(evt_cnt) == 5'(CLAMP_EVENTS)) else $error("clamp early");
  chk_soft_guard: assert property (@(posedge core_clk) disable iff (!nrst)
    state == HCP_SOFT && !cmp.fb_above_hiccup |=> ovl_cnt == '0)
    else $error("overload counted too early");
  chk_comp_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    comp_taken && $past(comp_taken) |-> $stable(comp_internal))
    else $error("compensation changed");
  chk_clean_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    prot_en && state != HCP_PAUSE && cyc_stb && !oc_flag && ovl_cnt != '0
    && clean_cnt == 3'(CLEAN_CYCLES - 1) |=> ovl_cnt == '0)
    else $error("overload not cleared");

  // Overload expiry, then pause with both drives and soft start held off
  sequence s_ovl_expired;
    state != HCP_PAUSE && ovl_cnt == ($bits(ovl_cnt))'(OVL_N);
  endsequence
  sequence s_pause_entered;
    state == HCP_PAUSE && pause_cnt == '0
    ##1 !high_side_gate_drive && !low_side_gate_drive && !soft_start_run && hiccup_active;
  endsequence
  chk_hiccup_entry: assert property (@(posedge core_clk) disable iff (!nrst)
    s_ovl_expired |=> s_pause_entered) else $error("hiccup entry incomplete");
endmodule : hcp_hiccup

// ---- rtl/hcp_pkg.sv ----
// Purpose: Shared constants and types for the hiccup overcurrent sequencer
// Assumes: core_clk at 100 MHz; one switching-cycle strobe from the oscillator
// Notes: Counts are in switching cycles, except SS_CYCLES which is in core_clk cycles
package hcp_pkg;
  // Overload and pause counts in switching cycles
  localparam int unsigned OVL_CYCLES = 512;
  localparam int unsigned CLEAN_CYCLES = 4;
  localparam int unsigned PAUSE_CYCLES = 16384;
  localparam int unsigned CLAMP_EVENTS = 16;
  // Soft-start duration
  localparam real SS_TIME_MS = 3.0;
  localparam real CLK_MHZ = 100.0;
  localparam int unsigned SS_CYCLES = int'(SS_TIME_MS * 1000.0 * CLK_MHZ);
  // Sequencer modes
  typedef enum logic [1:0] {
    HCP_SOFT,
    HCP_RUN,
    HCP_PAUSE
  } hcp_state_t;
  // Analog comparator inputs bundled together
  typedef struct packed {
    logic curr_limit;
    logic fb_above_hiccup;
    logic fb_above_clamp;
  } hcp_cmp_t;
endpackage : hcp_pkg

// ---- rtl/hcp_sync.sv ----
// Purpose: Two-flop synchroniser, width parameterised
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module hcp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  // Double register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : hcp_sync

// ---- tb/hcp_stage_model.sv ----
// Purpose: Power stage model: oscillator, limit comparator, feedback levels
// Assumes: Bench drives overload and fb_ok at the falling edge
// Notes: Comparator trips only in the on part of a 20-clock cycle
`timescale 1ns/1ps
module hcp_stage_model
  import hcp_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Bench controls
  input wire logic overload,
  input wire logic fb_ok,
  // To the sequencer; phase goes to the bench only
  output hcp_cmp_t cmp_out,
  output logic cycle_start,
  output logic pwm_on,
  output logic [4:0] phase
);
  //////////////////////////////////////////////////////////////////////////////
  logic [4:0] ph = 5'h00;
  // Free running oscillator, 20 clocks a cycle
  always @(negedge core_clk) begin
    ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
  end
  assign phase = ph;
  // Sensed current rises only while the high side conducts
  always_comb begin
    cycle_start = (phase < 5'h0A);
    pwm_on = (phase < 5'h0A);
    cmp_out.curr_limit = overload && (phase > 5'h01) && (phase < 5'h0A);
    cmp_out.fb_above_hiccup = fb_ok;
    cmp_out.fb_above_clamp = fb_ok;
  end
endmodule : hcp_stage_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the hiccup sequencer
// Assumes: Shortened counts; one switching cycle is 20 clocks
// Notes: Scenarios run in sequence from one reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import hcp_pkg::*;
  localparam int OVL = 32;
  localparam int PAUSE = 16;
  localparam int SS = 800;
  localparam int CYC = 20;
  logic core_clk, nrst, pin, overload, fb_ok, cyc, pwm;
  logic hs, ls, ssr, ssd, clamp, comp, hic, hic_seen, clamp_seen;
  logic [4:0] phase;
  hcp_cmp_t cmp;
  int err_total, compares, ticks, n, t0;
  hcp_stage_model hcp_stage_model_inst (.core_clk(core_clk), .overload(overload),
    .fb_ok(fb_ok), .cmp_out(cmp), .cycle_start(cyc), .pwm_on(pwm), .phase(phase));
  hcp_hiccup #(.OVL_N(OVL), .PAUSE_N(PAUSE), .SS_N(SS)) hcp_hiccup_inst (
    .core_clk(core_clk), .nrst(nrst), .cmp_in(cmp), .cycle_start(cyc),
    .compensation_select_pin(pin), .pwm_on(pwm), .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .soft_start_run(ssr), .soft_start_done(ssd),
    .ss_clamp_en(clamp), .comp_internal(comp), .hiccup_active(hic));
  //////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and sticky flags
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ticks++;
    if (hic === 1'b1) hic_seen = 1'b1;
    if (clamp === 1'b1) clamp_seen = 1'b1;
    if (ticks == 20000) begin
      err_total++;
      stop_test();
    end
  end
  // Bounded wait for soft start done (sel 0) or pause (sel 1)
  task wait_on(input int sel, input logic lvl);
    n = 0;
    while (((sel == 0) ? ssd : hic) !== lvl && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_on
  task t_soft();
    overload = 1'b1;
    repeat (10 * CYC) @(negedge core_clk);
    `CHK("clamp_early", 1'b0, clamp);
    repeat (SS - 100 - 10 * CYC) @(negedge core_clk);
    `CHK("hic_soft", 1'b0, hic);
    `CHK("ssd_early", 1'b0, ssd);
    `CHK("comp_held", 1'b1, comp);
    wait_on(0, 1'b1);
    `CHK("ssd_time", 1'b1, n < 200);
  endtask : t_soft
  task t_hiccup();
    t0 = ticks;
    fb_ok = 1'b1;
    clamp_seen = 1'b0;
    while (phase !== 5'h09) @(negedge core_clk);
    `CHK("hs_trip", 1'b0, hs);
    wait_on(1, 1'b1);
    n = ticks - t0;
    `CHK("ovl_len", 1'b1, n >= (OVL - 2) * CYC && n <= (OVL + 2) * CYC);
    `CHK("clamp_on", 1'b1, clamp_seen);
    `CHK("drives_off", 3'h0, {hs, ls, ssr});
    overload = 1'b0;
    wait_on(1, 1'b0);
    `CHK("pause_len", 1'b1, n >= (PAUSE - 1) * CYC && n <= (PAUSE + 2) * CYC);
    `CHK("ss_release", 1'b1, ssr);
  endtask : t_hiccup
  task t_clean();
    wait_on(0, 1'b1);
    while (phase !== 5'h00) @(negedge core_clk);
    hic_seen = 1'b0;
    repeat (10) begin
      overload = 1'b1;
      repeat (3 * CYC) @(negedge core_clk);
      overload = 1'b0;
      repeat (4 * CYC) @(negedge core_clk);
    end
    repeat (9) @(negedge core_clk);
    `CHK("hs_clean", 1'b1, hs);
    `CHK("no_hic", 1'b0, hic_seen);
    repeat (8) begin
      overload = 1'b1;
      repeat (3 * CYC) @(negedge core_clk);
      overload = 1'b0;
      repeat (3 * CYC) @(negedge core_clk);
    end
    `CHK("hic_dirty", 1'b1, hic_seen);
  endtask : t_clean
  task t_reset();
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("rst_out", 3'h0, {hic, clamp, comp});
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("comp_ext", 1'b0, comp);
  endtask : t_reset
  task stop_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    {nrst, overload, fb_ok, hic_seen, clamp_seen} = 5'h00;
    pin = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("hs_rst", 1'b0, hs);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("comp_int", 1'b1, comp);
    pin = 1'b0;
    t_soft();
    t_hiccup();
    t_clean();
    t_reset();
    stop_test();
  end
endmodule : tb_top
